// >>> design/omd_decoder.sv
// Opcode map decoder: classifies one instruction word per cycle and
// resolves add results, branch outcomes, links and delay-slot kills.
// Assumes word, pc and operands arrive on clk_sys from fetch/read logic.
//
// Functional notes
// - Primary opcode is bits 31..26; four codes open the submaps.
// - Any reserved encoding raises reserved-instruction, no operation done.
// - Listed primary codes and zero-function 000001 raise coprocessor-unusable.
// - Zero-function submap decodes rows 000..110; gaps and row 111 reserved.
// - Second-function submap: multiply-add/sub, product, lead counts, debug break.
// - Register-immediate rt: branches, immediate traps, linking branches; rest reserved.
// - System unit rs: move-from 00000, move-to 00100, rs bit 4 set selects the operation group, others reserved.
// - Operation group functions: translation ops, returns, wait; rest reserved.
// - Fields are matched against fixed five or six bit codes.
// - Adds write A plus B, or A plus immediate, to their dest.
// - Equal-likely branch taken on equality, else delay slot ignored.
// - Greater-or-equal-zero branches taken exactly when A bit 31 clear.
// - Linking branches always write pc plus 8 into register 31.
// - Greater-than-zero taken when A positive and nonzero; likely nullifies.
// - Less-or-equal-zero taken when A negative or zero; likely nullifies.
// - Less-than-zero branch taken exactly when A bit 31 set.
// - A not-taken likely branch nullifies its delay-slot instruction.
`timescale 1ns/10ps
`include "omd_params.svh"

module omd_decoder (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] source_a,
  input wire logic [31:0] source_b,
  output logic dec_valid,
  output omd_pkg::omd_op_e dec_op,
  output logic resv_exc,
  output logic unusable_exc,
  output logic wr_en,
  output logic [4:0] wr_dest,
  output logic [31:0] wr_data,
  output logic br_valid,
  output logic br_taken,
  output logic [31:0] br_target,
  output logic link_en,
  output logic [31:0] link_data,
  output logic nullify_slot
);

  // ==========================================================
  // Decode functions
  function automatic omd_pkg::omd_op_e zero_fn_decode(
    input logic [5:0] fn
  );
    omd_pkg::omd_op_e res;
    res = omd_pkg::OMD_OP_RESERVED;
    case (fn)
      6'h00, 6'h02, 6'h03, 6'h04, 6'h06, 6'h07: begin
        res = omd_pkg::OMD_OP_SHIFT;
      end
      `OMD_FN_UNUSABLE: begin
        res = omd_pkg::OMD_OP_UNUSABLE;
      end
      6'h08, 6'h09: begin
        res = omd_pkg::OMD_OP_JUMP_REG;
      end
      6'h0A, 6'h0B: begin
        res = omd_pkg::OMD_OP_COND_MOVE;
      end
      6'h0C: begin
        res = omd_pkg::OMD_OP_SYSCALL;
      end
      6'h0D: begin
        res = omd_pkg::OMD_OP_BREAK;
      end
      6'h0F: begin
        res = omd_pkg::OMD_OP_SYNC;
      end
      6'h10, 6'h11, 6'h12, 6'h13: begin
        res = omd_pkg::OMD_OP_HILO;
      end
      6'h18, 6'h19, 6'h1A, 6'h1B: begin
        res = omd_pkg::OMD_OP_MULDIV;
      end
      `OMD_FN_SUM, `OMD_FN_SUM_U: begin
        res = omd_pkg::OMD_OP_ADD;
      end
      6'h22, 6'h23: begin
        res = omd_pkg::OMD_OP_SUB;
      end
      6'h24, 6'h25, 6'h26, 6'h27: begin
        res = omd_pkg::OMD_OP_LOGIC;
      end
      6'h2A, 6'h2B: begin
        res = omd_pkg::OMD_OP_SET_LESS;
      end
      6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h36: begin
        res = omd_pkg::OMD_OP_TRAP;
      end
      default: begin
        res = omd_pkg::OMD_OP_RESERVED;
      end
    endcase
    return res;
  endfunction : zero_fn_decode

  function automatic omd_pkg::omd_op_e second_fn_decode(
    input logic [5:0] fn
  );
    omd_pkg::omd_op_e res;
    case (fn)
      `OMD_F2_MACC, `OMD_F2_MACC_U: begin
        res = omd_pkg::OMD_OP_MACC;
      end
      `OMD_F2_PROD: begin
        res = omd_pkg::OMD_OP_PROD;
      end
      `OMD_F2_MDED, `OMD_F2_MDED_U: begin
        res = omd_pkg::OMD_OP_MDED;
      end
      `OMD_F2_LEAD_ZERO: begin
        res = omd_pkg::OMD_OP_LEAD_ZERO;
      end
      `OMD_F2_LEAD_ONE: begin
        res = omd_pkg::OMD_OP_LEAD_ONE;
      end
      `OMD_F2_SOFT_BREAK: begin
        res = omd_pkg::OMD_OP_SOFT_BREAK;
      end
      default: begin
        res = omd_pkg::OMD_OP_RESERVED;
      end
    endcase
    return res;
  endfunction : second_fn_decode

  function automatic omd_pkg::omd_op_e reg_imm_decode(
    input logic [4:0] rt
  );
    omd_pkg::omd_op_e res;
    case (rt)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h12, 5'h13: begin
        res = omd_pkg::OMD_OP_BRANCH;
      end
      5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E: begin
        res = omd_pkg::OMD_OP_TRAP_IMM;
      end
      default: begin
        res = omd_pkg::OMD_OP_RESERVED;
      end
    endcase
    return res;
  endfunction : reg_imm_decode

  function automatic omd_pkg::omd_op_e sys_unit_decode(
    input logic [4:0] rs,
    input logic [5:0] fn
  );
    omd_pkg::omd_op_e res;
    res = omd_pkg::OMD_OP_RESERVED;
    if (rs[4]) begin
      case (fn)
        `OMD_CO_XLATE_READ: res = omd_pkg::OMD_OP_XLATE_READ;
        `OMD_CO_XLATE_WI: res = omd_pkg::OMD_OP_XLATE_WI;
        `OMD_CO_XLATE_WR: res = omd_pkg::OMD_OP_XLATE_WR;
        `OMD_CO_XLATE_PROBE: res = omd_pkg::OMD_OP_XLATE_PROBE;
        `OMD_CO_EXC_RETURN: res = omd_pkg::OMD_OP_EXC_RETURN;
        `OMD_CO_DBG_RETURN: res = omd_pkg::OMD_OP_DBG_RETURN;
        `OMD_CO_WAIT: res = omd_pkg::OMD_OP_WAIT;
        default: res = omd_pkg::OMD_OP_RESERVED;
      endcase
    end else if (rs == `OMD_RS_MOVE_FROM) begin
      res = omd_pkg::OMD_OP_MOVE_FROM_SYS;
    end else if (rs == `OMD_RS_MOVE_TO) begin
      res = omd_pkg::OMD_OP_MOVE_TO_SYS;
    end
    return res;
  endfunction : sys_unit_decode

  function automatic omd_pkg::omd_op_e primary_decode(
    input logic [31:0] iw
  );
    omd_pkg::omd_op_e res;
    logic [5:0] op;
    op = iw[`OMD_OP_MSB:`OMD_OP_LSB];
    case (op)
      `OMD_OP_ZERO_FN: res = zero_fn_decode(iw[`OMD_FN_MSB:`OMD_FN_LSB]);
      `OMD_OP_REG_IMM: res = reg_imm_decode(iw[`OMD_RT_MSB:`OMD_RT_LSB]);
      `OMD_OP_SECOND_FN: res = second_fn_decode(iw[`OMD_FN_MSB:`OMD_FN_LSB]);
      `OMD_OP_SYS_UNIT: begin
        res = sys_unit_decode(iw[`OMD_RS_MSB:`OMD_RS_LSB],
                              iw[`OMD_FN_MSB:`OMD_FN_LSB]);
      end
      `OMD_OP_JUMP, `OMD_OP_JUMP_LINK: res = omd_pkg::OMD_OP_JUMP;
      `OMD_OP_BR_EQ, `OMD_OP_BR_NE, `OMD_OP_BR_LE_ZERO,
      `OMD_OP_BR_GT_ZERO, `OMD_OP_BR_EQ_LIKELY, `OMD_OP_BR_NE_LIKELY,
      `OMD_OP_BR_LE_ZERO_LIKELY, `OMD_OP_BR_GT_ZERO_LIKELY: begin
        res = omd_pkg::OMD_OP_BRANCH;
      end
      `OMD_OP_SUM_IMM, `OMD_OP_SUM_IMM_U: res = omd_pkg::OMD_OP_ADD;
      6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F: begin
        res = omd_pkg::OMD_OP_ALU_IMM;
      end
      6'h11, 6'h12, 6'h13, 6'h31, 6'h32, 6'h35, 6'h36, 6'h39, 6'h3A,
      6'h3D, 6'h3E: begin
        res = omd_pkg::OMD_OP_UNUSABLE;
      end
      6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h28, 6'h29,
      6'h2A, 6'h2B, 6'h2E, `OMD_OP_CACHE, 6'h30, `OMD_OP_PREFETCH,
      6'h38: begin
        res = omd_pkg::OMD_OP_MEMORY;
      end
      default: res = omd_pkg::OMD_OP_RESERVED;
    endcase
    return res;
  endfunction : primary_decode

  // ==========================================================
  // Combinational decode of the current word
  logic [5:0] op_fld;
  logic [4:0] rt_fld;
  logic [31:0] imm_sext;
  logic [31:0] slot_pc;
  logic a_zero;
  logic a_neg;
  omd_pkg::omd_op_e op_cls;
  logic is_branch;
  logic is_likely;
  logic is_link;
  logic cond_met;
  logic is_add;
  logic add_imm;

  assign op_fld = instr_word[`OMD_OP_MSB:`OMD_OP_LSB];
  assign rt_fld = instr_word[`OMD_RT_MSB:`OMD_RT_LSB];
  assign imm_sext = {{16{instr_word[`OMD_IMM_MSB]}},
                     instr_word[`OMD_IMM_MSB:`OMD_IMM_LSB]};
  assign slot_pc = instr_pc + `OMD_SLOT_OFFSET;
  assign a_zero = (source_a == 32'h0000_0000);
  assign a_neg = source_a[31];
  assign op_cls = primary_decode(instr_word);
  assign is_branch = (op_cls == omd_pkg::OMD_OP_BRANCH);
  assign is_add = (op_cls == omd_pkg::OMD_OP_ADD);
  assign add_imm = (op_fld == `OMD_OP_SUM_IMM) ||
                   (op_fld == `OMD_OP_SUM_IMM_U);

  // Likely forms: primary row 010, or register-immediate rt bit 1
  always_comb begin
    is_likely = 1'b0;
    is_link = 1'b0;
    cond_met = 1'b0;
    if (op_fld == `OMD_OP_REG_IMM) begin
      is_likely = rt_fld[1];
      is_link = rt_fld[4];
      cond_met = rt_fld[0] ? !a_neg : a_neg;
    end else begin
      is_likely = op_fld[4];
      case (op_fld[1:0])
        2'b00: cond_met = (source_a == source_b);
        2'b01: cond_met = (source_a != source_b);
        2'b10: cond_met = a_neg || a_zero;
        2'b11: cond_met = !a_neg && !a_zero;
        default: cond_met = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Registered outputs, one cycle after the word
  logic dec_valid_r;
  omd_pkg::omd_op_e dec_op_r;
  logic resv_exc_r;
  logic unusable_exc_r;
  logic wr_en_r;
  logic [4:0] wr_dest_r;
  logic [31:0] wr_data_r;
  logic br_valid_r;
  logic br_taken_r;
  logic [31:0] br_target_r;
  logic link_en_r;
  logic [31:0] link_data_r;
  logic nullify_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dec_valid_r <= 1'b0;
      dec_op_r <= omd_pkg::OMD_OP_NONE;
      resv_exc_r <= 1'b0;
      unusable_exc_r <= 1'b0;
    end else begin
      dec_valid_r <= instr_valid;
      dec_op_r <= instr_valid ? op_cls : omd_pkg::OMD_OP_NONE;
      resv_exc_r <= instr_valid && (op_cls == omd_pkg::OMD_OP_RESERVED);
      unusable_exc_r <= instr_valid &&
                        (op_cls == omd_pkg::OMD_OP_UNUSABLE);
    end
  end

  // Only decoded adds reach the write port; exceptions never write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_en_r <= 1'b0;
      wr_dest_r <= 5'h00;
      wr_data_r <= 32'h0000_0000;
    end else begin
      wr_en_r <= instr_valid && is_add;
      if (instr_valid && is_add) begin
        wr_data_r <= source_a + (add_imm ? imm_sext : source_b);
        wr_dest_r <= add_imm ? rt_fld
                             : instr_word[`OMD_RD_MSB:`OMD_RD_LSB];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      br_valid_r <= 1'b0;
      br_taken_r <= 1'b0;
      br_target_r <= 32'h0000_0000;
      link_en_r <= 1'b0;
      link_data_r <= 32'h0000_0000;
      nullify_r <= 1'b0;
    end else begin
      br_valid_r <= instr_valid && is_branch;
      br_taken_r <= instr_valid && is_branch && cond_met;
      link_en_r <= instr_valid && is_branch && is_link;
      nullify_r <= instr_valid && is_branch && is_likely &&
                   !cond_met;
      if (instr_valid && is_branch) begin
        br_target_r <= slot_pc + {imm_sext[29:0], 2'b00};
        link_data_r <= instr_pc + `OMD_LINK_OFFSET;
      end
    end
  end

  assign dec_valid = dec_valid_r;
  assign dec_op = dec_op_r;
  assign resv_exc = resv_exc_r;
  assign unusable_exc = unusable_exc_r;
  assign wr_en = wr_en_r;
  assign wr_dest = wr_dest_r;
  assign wr_data = wr_data_r;
  assign br_valid = br_valid_r;
  assign br_taken = br_taken_r;
  assign br_target = br_target_r;
  assign link_en = link_en_r;
  assign link_data = link_data_r;
  assign nullify_slot = nullify_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_UNUSABLE_PRIMARY: assert property (
    instr_valid && (instr_word[31:26] inside {6'h11, 6'h12, 6'h13}) |=>
    unusable_exc && !resv_exc)
    else $error("coprocessor-unusable code not flagged");

  AST_RESERVED_ROW7: assert property (
    instr_valid && instr_word[31:26] == 6'h00 && instr_word[5:3] == 3'h7
    |=> resv_exc && !wr_en)
    else $error("zero-function row 111 not reserved");

  AST_EXC_NO_EFFECT: assert property (
    resv_exc || unusable_exc |-> !wr_en && !br_taken && !link_en)
    else $error("excepting instruction had an effect");

  AST_SUM_RESULT: assert property (
    instr_valid && instr_word[31:26] == 6'h00 && instr_word[5:0] == 6'h21
    |=> wr_en && wr_data == $past(source_a) + $past(source_b) &&
        wr_dest == $past(instr_word[15:11]))
    else $error("register add result wrong");

  AST_SUM_IMM_DEST: assert property (
    instr_valid && instr_word[31:26] == 6'h09 |=>
    wr_en && wr_dest == $past(instr_word[20:16]))
    else $error("immediate add destination wrong");

  AST_LINK_ALWAYS: assert property (
    instr_valid && instr_word[31:26] == 6'h01 &&
    instr_word[20:16] inside {5'h10, 5'h11} |=>
    link_en && link_data == $past(instr_pc) + 32'h0000_0008)
    else $error("link not written with pc plus 8");

  AST_GE_ZERO_TAKEN: assert property (
    instr_valid && instr_word[31:26] == 6'h01 && instr_word[20:16] == 5'h01
    |=> br_taken == !$past(source_a[31]))
    else $error("greater-or-equal-zero outcome wrong");

  AST_GT_ZERO_TAKEN: assert property (
    instr_valid && instr_word[31:26] == 6'h17 |=>
    br_taken == ($past(source_a) != 32'h0 && !$past(source_a[31])) &&
    nullify_slot == !br_taken)
    else $error("greater-than-zero likely outcome wrong");

  AST_EQ_LIKELY_NULL: assert property (
    instr_valid && instr_word[31:26] == 6'h14 &&
    source_a != source_b |=> !br_taken ##0 nullify_slot)
    else $error("equal-likely not-taken slot not nullified");

  AST_TARGET: assert property (
    instr_valid && instr_word[31:26] == 6'h04 |=>
    br_target == $past(instr_pc) + 32'h0000_0004 +
                 {{14{$past(instr_word[15])}}, $past(instr_word[15:0]), 2'b00})
    else $error("branch target wrong");

  AST_OP_GROUP: assert property (
    instr_valid && instr_word[31:26] == 6'h10 && instr_word[25] &&
    instr_word[5:0] == 6'h18 |=> dec_op == omd_pkg::OMD_OP_EXC_RETURN)
    else $error("operation group not selected by rs bit 25");

endmodule : omd_decoder

// >>> pkg/omd_params.svh
// Field positions, opcode codes and link constants for the opcode decoder.
// Assumes inclusion by bare name from the design files.
`ifndef OMD_PARAMS_SVH
`define OMD_PARAMS_SVH

// Instruction field positions
`define OMD_OP_MSB 31
`define OMD_OP_LSB 26
`define OMD_RS_MSB 25
`define OMD_RS_LSB 21
`define OMD_RT_MSB 20
`define OMD_RT_LSB 16
`define OMD_RD_MSB 15
`define OMD_RD_LSB 11
`define OMD_FN_MSB 5
`define OMD_FN_LSB 0
`define OMD_IMM_MSB 15
`define OMD_IMM_LSB 0

// Primary opcodes
`define OMD_OP_ZERO_FN 6'h00
`define OMD_OP_REG_IMM 6'h01
`define OMD_OP_JUMP 6'h02
`define OMD_OP_JUMP_LINK 6'h03
`define OMD_OP_BR_EQ 6'h04
`define OMD_OP_BR_NE 6'h05
`define OMD_OP_BR_LE_ZERO 6'h06
`define OMD_OP_BR_GT_ZERO 6'h07
`define OMD_OP_SUM_IMM 6'h08
`define OMD_OP_SUM_IMM_U 6'h09
`define OMD_OP_SYS_UNIT 6'h10
`define OMD_OP_BR_EQ_LIKELY 6'h14
`define OMD_OP_BR_NE_LIKELY 6'h15
`define OMD_OP_BR_LE_ZERO_LIKELY 6'h16
`define OMD_OP_BR_GT_ZERO_LIKELY 6'h17
`define OMD_OP_SECOND_FN 6'h1C
`define OMD_OP_CACHE 6'h2F
`define OMD_OP_PREFETCH 6'h33

// Zero-function submap codes
`define OMD_FN_UNUSABLE 6'h01
`define OMD_FN_SUM 6'h20
`define OMD_FN_SUM_U 6'h21

// Second-function submap codes
`define OMD_F2_MACC 6'h00
`define OMD_F2_MACC_U 6'h01
`define OMD_F2_PROD 6'h02
`define OMD_F2_MDED 6'h04
`define OMD_F2_MDED_U 6'h05
`define OMD_F2_LEAD_ZERO 6'h20
`define OMD_F2_LEAD_ONE 6'h21
`define OMD_F2_SOFT_BREAK 6'h3F

// System-unit rs and operation-group function codes
`define OMD_RS_MOVE_FROM 5'h00
`define OMD_RS_MOVE_TO 5'h04
`define OMD_CO_XLATE_READ 6'h01
`define OMD_CO_XLATE_WI 6'h02
`define OMD_CO_XLATE_WR 6'h06
`define OMD_CO_XLATE_PROBE 6'h08
`define OMD_CO_EXC_RETURN 6'h18
`define OMD_CO_DBG_RETURN 6'h1F
`define OMD_CO_WAIT 6'h20

// Link and branch arithmetic
`define OMD_LINK_OFFSET 32'h0000_0008
`define OMD_SLOT_OFFSET 32'h0000_0004
`define OMD_LINK_REG 5'h1F

`endif

// >>> pkg/omd_pkg.sv
// Types shared by the opcode decoder and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package omd_pkg;

  // ==========================================================
  // Decoded operation class
  typedef enum logic [5:0] {
    OMD_OP_NONE = 6'h00,
    OMD_OP_RESERVED = 6'h01,
    OMD_OP_UNUSABLE = 6'h02,
    OMD_OP_SHIFT = 6'h03,
    OMD_OP_JUMP_REG = 6'h04,
    OMD_OP_COND_MOVE = 6'h05,
    OMD_OP_SYSCALL = 6'h06,
    OMD_OP_BREAK = 6'h07,
    OMD_OP_SYNC = 6'h08,
    OMD_OP_HILO = 6'h09,
    OMD_OP_MULDIV = 6'h0A,
    OMD_OP_ADD = 6'h0B,
    OMD_OP_SUB = 6'h0C,
    OMD_OP_LOGIC = 6'h0D,
    OMD_OP_SET_LESS = 6'h0E,
    OMD_OP_TRAP = 6'h0F,
    OMD_OP_MACC = 6'h10,
    OMD_OP_PROD = 6'h11,
    OMD_OP_MDED = 6'h12,
    OMD_OP_LEAD_ZERO = 6'h13,
    OMD_OP_LEAD_ONE = 6'h14,
    OMD_OP_SOFT_BREAK = 6'h15,
    OMD_OP_BRANCH = 6'h16,
    OMD_OP_TRAP_IMM = 6'h17,
    OMD_OP_MOVE_FROM_SYS = 6'h18,
    OMD_OP_MOVE_TO_SYS = 6'h19,
    OMD_OP_XLATE_READ = 6'h1A,
    OMD_OP_XLATE_WI = 6'h1B,
    OMD_OP_XLATE_WR = 6'h1C,
    OMD_OP_XLATE_PROBE = 6'h1D,
    OMD_OP_EXC_RETURN = 6'h1E,
    OMD_OP_DBG_RETURN = 6'h1F,
    OMD_OP_WAIT = 6'h20,
    OMD_OP_JUMP = 6'h21,
    OMD_OP_ALU_IMM = 6'h22,
    OMD_OP_MEMORY = 6'h23
  } omd_op_e;

endpackage : omd_pkg

// >>> verification/omd_fetch_model.sv
// Fetch-side model: hands instruction words and operands to the decoder.
// Assumes every call is made on a falling edge of clk_sys.
`timescale 1ns/10ps

module omd_fetch_model (
  input wire logic clk_sys,
  output logic instr_valid,
  output logic [31:0] instr_word,
  output logic [31:0] instr_pc,
  output logic [31:0] source_a,
  output logic [31:0] source_b
);
  // ==========================================================
  // Word presentation
  initial begin
    instr_valid = 1'b0;
    instr_word = 32'h0000_0000;
    instr_pc = 32'h0000_0000;
    source_a = 32'h0000_0000;
    source_b = 32'h0000_0000;
  end

  // Valid stays up between calls, so loops stream back to back
  task automatic send(input logic [31:0] w, input logic [31:0] pc,
    input logic [31:0] a, input logic [31:0] b);
    instr_valid = 1'b1;
    instr_word = w;
    instr_pc = pc;
    source_a = a;
    source_b = b;
    @(negedge clk_sys);
  endtask : send

  // Stale fields flip so a lost valid can never pass as a repeat
  task automatic idle;
    instr_valid = 1'b0;
    instr_word = ~instr_word;
    instr_pc = ~instr_pc;
    source_a = ~source_a;
    source_b = ~source_b;
    @(negedge clk_sys);
  endtask : idle
endmodule : omd_fetch_model

// >>> verification/testbench.sv
// Bench for the opcode decoder: sweeps of every map, adds and branches.
// Assumes a fixed one-cycle answer and no back-pressure.
`timescale 1ns/10ps

module testbench;
  logic clk_sys, nrst, instr_valid;
  logic [31:0] instr_word, instr_pc, source_a, source_b;
  logic dec_valid, resv_exc, unusable_exc, wr_en, br_valid, br_taken;
  logic link_en, nullify_slot;
  logic [4:0] wr_dest;
  logic [31:0] wr_data, br_target, link_data;
  omd_pkg::omd_op_e dec_op;
  int checks = 0;
  int miscompares = 0;

  omd_fetch_model omd_fetch_model_i (.clk_sys(clk_sys),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_pc(instr_pc), .source_a(source_a), .source_b(source_b));

  omd_decoder omd_decoder_i (.clk_sys(clk_sys), .nrst(nrst),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_pc(instr_pc), .source_a(source_a), .source_b(source_b),
    .dec_valid(dec_valid), .dec_op(dec_op), .resv_exc(resv_exc),
    .unusable_exc(unusable_exc), .wr_en(wr_en), .wr_dest(wr_dest),
    .wr_data(wr_data), .br_valid(br_valid), .br_taken(br_taken),
    .br_target(br_target), .link_en(link_en), .link_data(link_data),
    .nullify_slot(nullify_slot));

  // ==========================================================
  // Helpers
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] mk(input logic [5:0] op,
    input logic [4:0] rs, input logic [4:0] rt, input logic [5:0] fn);
    return {op, rs, rt, 5'h03, 5'h00, fn};
  endfunction : mk

  // Result is {reserved, unusable}
  function automatic logic [1:0] exp_prim(input logic [5:0] op);
    case (op)
      6'h11, 6'h12, 6'h13, 6'h31, 6'h32, 6'h35, 6'h36, 6'h39, 6'h3A,
      6'h3D, 6'h3E: return 2'h1;
      6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1D, 6'h1E, 6'h1F, 6'h27, 6'h2C,
      6'h2D, 6'h34, 6'h37, 6'h3B, 6'h3C, 6'h3F: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction : exp_prim

  function automatic logic [1:0] exp_zero(input logic [5:0] fn);
    case (fn)
      6'h01: return 2'h1;
      6'h05, 6'h0E, 6'h14, 6'h15, 6'h16, 6'h17, 6'h1C, 6'h1D, 6'h1E,
      6'h1F, 6'h28, 6'h29, 6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h35,
      6'h37: return 2'h2;
      default: return (fn[5:3] == 3'h7) ? 2'h2 : 2'h0;
    endcase
  endfunction : exp_zero

  function automatic omd_pkg::omd_op_e exp_f2(input logic [5:0] fn);
    case (fn)
      6'h00, 6'h01: return omd_pkg::OMD_OP_MACC;
      6'h02: return omd_pkg::OMD_OP_PROD;
      6'h04, 6'h05: return omd_pkg::OMD_OP_MDED;
      6'h20: return omd_pkg::OMD_OP_LEAD_ZERO;
      6'h21: return omd_pkg::OMD_OP_LEAD_ONE;
      6'h3F: return omd_pkg::OMD_OP_SOFT_BREAK;
      default: return omd_pkg::OMD_OP_RESERVED;
    endcase
  endfunction : exp_f2

  function automatic omd_pkg::omd_op_e exp_grp(input logic [5:0] fn);
    case (fn)
      6'h01: return omd_pkg::OMD_OP_XLATE_READ;
      6'h02: return omd_pkg::OMD_OP_XLATE_WI;
      6'h06: return omd_pkg::OMD_OP_XLATE_WR;
      6'h08: return omd_pkg::OMD_OP_XLATE_PROBE;
      6'h18: return omd_pkg::OMD_OP_EXC_RETURN;
      6'h1F: return omd_pkg::OMD_OP_DBG_RETURN;
      6'h20: return omd_pkg::OMD_OP_WAIT;
      default: return omd_pkg::OMD_OP_RESERVED;
    endcase
  endfunction : exp_grp

  function automatic omd_pkg::omd_op_e exp_ri(input logic [4:0] rt);
    if (rt[4:2] == 3'h0 || rt[4:2] == 3'h4) return omd_pkg::OMD_OP_BRANCH;
    if (rt[4:3] == 2'h1 && rt != 5'h0D && rt != 5'h0F)
      return omd_pkg::OMD_OP_TRAP_IMM;
    return omd_pkg::OMD_OP_RESERVED;
  endfunction : exp_ri

  // ==========================================================
  // Scenarios
  task automatic t_primary;
    logic [1:0] e;
    for (int i = 0; i < 64; i++) begin
      e = exp_prim(6'(i));
      omd_fetch_model_i.send(mk(6'(i), 5'h00, 5'h00, 6'h00), 32'h0,
        32'h0, 32'h0);
      chk("prim resv", {31'h0, e[1]}, resv_exc);
      chk("prim unus", {31'h0, e[0]}, unusable_exc);
      chk("prim wr", {31'h0, i == 8 || i == 9}, wr_en);
    end
  endtask : t_primary

  task automatic t_zero;
    logic [1:0] e;
    for (int i = 0; i < 64; i++) begin
      e = exp_zero(6'(i));
      omd_fetch_model_i.send(mk(6'h00, 5'h01, 5'h02, 6'(i)), 32'h0,
        32'h5, 32'h7);
      chk("zero resv", {31'h0, e[1]}, resv_exc);
      chk("zero unus", {31'h0, e[0]}, unusable_exc);
      chk("zero wr", {31'h0, i == 32 || i == 33}, wr_en);
    end
  endtask : t_zero

  task automatic t_second;
    for (int i = 0; i < 64; i++) begin
      omd_fetch_model_i.send(mk(6'h1C, 5'h01, 5'h02, 6'(i)), 32'h0,
        32'h0, 32'h0);
      chk("f2 op", exp_f2(6'(i)), dec_op);
      chk("f2 resv", {31'h0, exp_f2(6'(i)) == omd_pkg::OMD_OP_RESERVED},
        resv_exc);
    end
  endtask : t_second

  // Negative then zero source, so both outcomes of every form are seen
  task automatic t_register_immediate_submap;
    logic [4:0] rt;
    logic [31:0] pc;
    logic ng;
    logic tk;
    for (int s = 0; s < 2; s++) begin
      ng = (s == 0);
      for (int i = 0; i < 32; i++) begin
        rt = 5'(i);
        pc = 32'h0000_1000 + {22'h0, rt, 5'h00};
        tk = rt[0] ^ ng;
        omd_fetch_model_i.send({6'h01, 5'h02, rt, 16'hFFFF}, pc,
          {ng, 31'h0}, 32'h0);
        chk("ri op", exp_ri(rt), dec_op);
        if (exp_ri(rt) == omd_pkg::OMD_OP_BRANCH) begin
          chk("ri taken", {31'h0, tk}, br_taken);
          chk("ri kill", {31'h0, rt[1] & ~tk}, nullify_slot);
          chk("ri link", {31'h0, rt[4]}, link_en);
          chk("ri target", pc, br_target);
          if (rt[4]) chk("ri ldata", pc + 32'h8, link_data);
        end
      end
    end
  endtask : t_register_immediate_submap

  task automatic t_sys;
    omd_pkg::omd_op_e e;
    for (int i = 0; i < 32; i++) begin
      e = omd_pkg::OMD_OP_RESERVED;
      if (i == 0) e = omd_pkg::OMD_OP_MOVE_FROM_SYS;
      if (i == 4) e = omd_pkg::OMD_OP_MOVE_TO_SYS;
      if (i >= 16) e = omd_pkg::OMD_OP_EXC_RETURN;
      omd_fetch_model_i.send(mk(6'h10, 5'(i), 5'h02, 6'h18), 32'h0,
        32'h0, 32'h0);
      chk("sys rs", e, dec_op);
    end
    for (int i = 0; i < 64; i++) begin
      omd_fetch_model_i.send(mk(6'h10, 5'h10, 5'h00, 6'(i)), 32'h0,
        32'h0, 32'h0);
      chk("sys fn", exp_grp(6'(i)), dec_op);
    end
  endtask : t_sys

  task automatic add_case(input logic [31:0] w, input logic [31:0] a,
    input logic [31:0] b, input logic [4:0] d, input logic [31:0] s);
    omd_fetch_model_i.send(w, 32'h0, a, b);
    chk("add en", 32'h1, wr_en);
    chk("add dest", {27'h0, d}, wr_dest);
    chk("add sum", s, wr_data);
  endtask : add_case

  task automatic br_case(input logic [5:0] op, input logic [31:0] a,
    input logic [31:0] b, input logic tk, input logic kl);
    omd_fetch_model_i.send({op, 5'h04, 5'h05, 16'h8000}, 32'h0000_0100,
      a, b);
    chk("br valid", 32'h1, br_valid);
    chk("br taken", {31'h0, tk}, br_taken);
    chk("br kill", {31'h0, kl}, nullify_slot);
    chk("br link", 32'h0, link_en);
    chk("br target", 32'h0000_0104 + 32'hFFFE_0000, br_target);
  endtask : br_case

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end

  initial begin
    nrst = 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("rst valid", 32'h0, dec_valid);
    chk("rst op", omd_pkg::OMD_OP_NONE, dec_op);
    @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    t_primary();
    t_zero();
    t_second();
    t_register_immediate_submap();
    t_sys();
    add_case(mk(6'h00, 5'h01, 5'h02, 6'h20), 32'h7FFF_0000, 32'h0000_FFFF,
      5'h03, 32'h7FFF_FFFF);
    add_case(mk(6'h00, 5'h01, 5'h02, 6'h21), 32'hFFFF_FFFF, 32'h2,
      5'h03, 32'h1);
    add_case({6'h08, 5'h01, 5'h09, 16'hFFFC}, 32'h10, 32'h0, 5'h09,
      32'hC);
    add_case({6'h09, 5'h01, 5'h1F, 16'h8000}, 32'h0, 32'h5, 5'h1F,
      32'hFFFF_8000);
    omd_fetch_model_i.idle();
    chk("gap valid", 32'h0, dec_valid);
    chk("gap wr", 32'h0, wr_en);
    br_case(6'h14, 32'h5, 32'h5, 1'b1, 1'b0);
    br_case(6'h14, 32'h5, 32'h6, 1'b0, 1'b1);
    br_case(6'h04, 32'h5, 32'h6, 1'b0, 1'b0);
    br_case(6'h05, 32'h5, 32'h6, 1'b1, 1'b0);
    br_case(6'h06, 32'h0, 32'h0, 1'b1, 1'b0);
    br_case(6'h06, 32'h8000_0000, 32'h0, 1'b1, 1'b0);
    br_case(6'h16, 32'h1, 32'h0, 1'b0, 1'b1);
    br_case(6'h07, 32'h0, 32'h0, 1'b0, 1'b0);
    br_case(6'h17, 32'h7FFF_FFFF, 32'h0, 1'b1, 1'b0);
    br_case(6'h17, 32'h8000_0000, 32'h0, 1'b0, 1'b1);
    omd_fetch_model_i.idle();
    report_and_stop();
  end
endmodule : testbench
